// ### hdl/imc_cal_engine.sv
// Calibration sequencer: clear stored values, optional foreground pass,
// then background running if enabled. Held in reset while calibration is disabled.
// Assumes single clock domain and software-supplied settings.
`timescale 1ns/1ns
`include "imc_defines.svh"
module imc_cal_engine
   import imc_pkg::*;
#(
   parameter logic [15:0] FG_CYCLES  = `IMC_FG_CYCLES,
   parameter logic [15:0] CLR_CYCLES = `IMC_CLR_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        calEnable,   // Low holds engine in reset
   input  wire imc_calsel_s calSel,      // Selection from software
   output logic             fgDone,      // Foreground done or skipped
   output logic             bgActive,    // Background calibration running
   output logic             applyPulse,  // Latch new settings now
   output imc_cal_e         calState     // Present state
);
   // Zero counts would wrap the phase counter
   if (FG_CYCLES == 16'h0000 || CLR_CYCLES == 16'h0000) begin : g_bad_counts
      $error("imc_cal_engine: counts must be nonzero");
   end

   imc_cal_e    state_r, state_nxt;      // Sequencer state
   logic [15:0] cnt_r, cnt_nxt;          // Phase counter
   logic        done_r, done_nxt;        // Foreground complete flag

   // Next-state logic
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      done_nxt  = done_r;
      case (state_r)
         CAL_HOLD: begin
            // Start: always clear stored values first
            state_nxt = CAL_CLEAR;
            cnt_nxt   = CLR_CYCLES - 16'h0001;
            done_nxt  = 1'b0;
         end
         CAL_CLEAR: begin
            if (cnt_r == 16'h0000) begin
               // Run or skip foreground pass
               if (calSel.fgRun) begin
                  state_nxt = CAL_FORE;
                  cnt_nxt   = FG_CYCLES - 16'h0001;
               end else begin
                  state_nxt = calSel.bgRun ? CAL_BACK : CAL_IDLE;
                  done_nxt  = 1'b1;
               end
            end else begin
               cnt_nxt = cnt_r - 16'h0001;
            end
         end
         CAL_FORE: begin
            if (cnt_r == 16'h0000) begin
               state_nxt = calSel.bgRun ? CAL_BACK : CAL_IDLE;
               done_nxt  = 1'b1;
            end else begin
               cnt_nxt = cnt_r - 16'h0001;
            end
         end
         CAL_BACK: begin
            // Background may be turned off on the fly
            if (!calSel.bgRun) state_nxt = CAL_IDLE;
         end
         CAL_IDLE: begin
            if (calSel.bgRun) state_nxt = CAL_BACK;
         end
         default: state_nxt = CAL_HOLD;
      endcase
   end

   // Registers; disabled calibration forces reset
   always_ff @(posedge ref_clk) begin
      if (!nrst || !calEnable) begin
         state_r <= CAL_HOLD;
         cnt_r   <= 16'h0000;
         done_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         done_r  <= done_nxt;
      end
   end

   assign fgDone     = done_r;
   assign bgActive   = (state_r == CAL_BACK);
   assign applyPulse = (state_r == CAL_HOLD) && calEnable && nrst;
   assign calState   = state_r;

   // Done flag clears while held
   hold_clears_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !calEnable |=> !fgDone) else $error("done flag not cleared");
   // Clear phase precedes any done
   clear_first_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(fgDone) |-> $past(state_r) inside {CAL_CLEAR, CAL_FORE})
      else $error("done without clear phase");
endmodule : imc_cal_engine

// ### hdl/imc_defines.svh
// Offsets, field positions, reset values and timing counts for the
// input routing and calibration control block.
// Assumes inclusion by bare name from design files.
`ifndef IMC_DEFINES_SVH
`define IMC_DEFINES_SVH
// Register indices (byte address is four times the index)
`define IMC_IDX_ROUTE     8'h60
`define IMC_IDX_CALEN     8'h61
`define IMC_IDX_CALCFG    8'h62
`define IMC_IDX_STATUS    8'h63
// Reset values
`define IMC_RST_ROUTE     8'h01
`define IMC_RST_CALEN     8'h01
`define IMC_RST_CALCFG    8'h01
// Field positions
`define IMC_ROUTE_SWAP    4
`define IMC_FOREGROUND_CALIBRATION_RUN        0
`define IMC_BACKGROUND_CALIBRATION_ENABLE        1
`define IMC_FOREGROUND_OFFSET_ENABLE        2
`define IMC_BACKGROUND_OFFSET_ENABLE      3
// Writable masks (reserved bits stay zero)
`define IMC_MASK_ROUTE    8'h13
`define IMC_MASK_CALEN    8'h01
`define IMC_MASK_CALCFG   8'h0f
// Default calibration durations in clock cycles
`define IMC_FG_CYCLES     16'h0100
`define IMC_CLR_CYCLES    16'h0010
`endif

// ### hdl/imc_pkg.sv
// Types for the input routing and calibration control block.
// Assumes nothing beyond the defines header.
package imc_pkg;
   // Calibration engine states
   typedef enum logic [2:0] {
      CAL_HOLD, CAL_CLEAR, CAL_FORE, CAL_BACK, CAL_IDLE
   } imc_cal_e;
   // Routing of the two converter channels
   typedef struct packed {
      logic       chanASamplesB;  // Channel A takes input_b
      logic       chanBSamplesA;  // Channel B takes input_a
      logic       chanBSamplesB;  // Channel B takes input_b
      logic       singleUsesB;    // Single mode samples input_b
      logic       dualInterleave; // Dual interleaved operation
   } imc_route_s;
   // Calibration selection as applied
   typedef struct packed {
      logic       fgRun;
      logic       bgRun;
      logic       fgOffset;
      logic       bgOffset;
   } imc_calsel_s;
endpackage : imc_pkg

// ### hdl/imc_top.sv
// Input routing and calibration control with an Avalon-MM slave.
// Assumes the converter mode setting and link enable come from logic
// on ref_clk, so they pass no synchroniser.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ns
`include "imc_defines.svh"
// Notes on behaviour
// - Swap bit crosses dual-channel inputs
// - Swap ignored in single-channel modes
// - Single input field: 1 A, 2 B
// - Single field ignored outside single mode
// - Code 3 gives dual interleaved routing
// - Mux changes apply when calibration starts
// - Enable low holds calibration in reset
// - Enable low resets processing clock dividers
// - Background offset needs background enable
// - Foreground offset needs foreground enable
// - Bit 1 enables background calibration
// - Start clears values, optional foreground
// - Foreground done flag readable
module imc_top
   import imc_pkg::*;
#(
   parameter logic [15:0] FG_CYCLES  = `IMC_FG_CYCLES,
   parameter logic [15:0] CLR_CYCLES = `IMC_CLR_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic [9:0]  avs_address,       // Byte address
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        singleChannelMode, // From converter_mode_setting
   input  wire logic        outputLinkEnable,  // output_link_enable level
   output imc_route_s       route,             // Applied input routing
   output imc_calsel_s      calApplied,        // Applied calibration select
   output logic             dividerReset,      // Resets processing dividers
   output logic             fgComplete,        // foreground_complete_flag
   output logic             bgActive           // Background cal running
);
   logic [7:0]  routeReg_r, routeReg_nxt;   // input_route_select
   logic [7:0]  calEn_r, calEn_nxt;         // calibration_enable
   logic [7:0]  calCfg_r, calCfg_nxt;       // calibration_config
   logic [31:0] rdata_r, rdata_nxt;         // Read data register
   logic        ack_r, ack_nxt;             // One-cycle answer
   imc_route_s  route_r, route_nxt;         // Latched routing
   imc_calsel_s calSel;                     // Selection into engine
   logic        applyPulse;                 // Engine start strobe
   logic        engFgDone;
   imc_cal_e    engState;
   logic [7:0]  idx;                        // Register index

   // Word index from byte address
   function automatic logic [7:0] word_index(input logic [9:0] a);
      return a[9:2];
   endfunction

   // Byte-lane merge for lane 0 with writable mask
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                        input logic be, input logic [7:0] mask);
      return be ? (wd & mask) : old;
   endfunction

   assign idx = word_index(avs_address);

   // Calibration selection with offset dependencies
   always_comb begin
      calSel.fgRun    = calCfg_r[`IMC_FOREGROUND_CALIBRATION_RUN];
      calSel.bgRun    = calCfg_r[`IMC_BACKGROUND_CALIBRATION_ENABLE];
      calSel.fgOffset = calCfg_r[`IMC_FOREGROUND_OFFSET_ENABLE] & calCfg_r[`IMC_FOREGROUND_CALIBRATION_RUN];
      calSel.bgOffset = calCfg_r[`IMC_BACKGROUND_OFFSET_ENABLE] & calCfg_r[`IMC_BACKGROUND_CALIBRATION_ENABLE];
   end

   imc_cal_engine #(
      .FG_CYCLES  (FG_CYCLES),
      .CLR_CYCLES (CLR_CYCLES)
   ) u_engine (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .calEnable  (calEn_r[0]),
      .calSel     (calSel),
      .fgDone     (engFgDone),
      .bgActive   (bgActive),
      .applyPulse (applyPulse),
      .calState   (engState)
   );

   // Bus slave and register next values
   always_comb begin
      routeReg_nxt = routeReg_r;
      calEn_nxt    = calEn_r;
      calCfg_nxt   = calCfg_r;
      rdata_nxt    = rdata_r;
      ack_nxt      = 1'b0;
      // Write lands at the edge where waitrequest is sampled low
      if (avs_write && ack_r) begin
         case (idx)
            `IMC_IDX_ROUTE:  routeReg_nxt = merge(routeReg_r, avs_writedata[7:0],
                                                  avs_byteenable[0], `IMC_MASK_ROUTE);
            `IMC_IDX_CALEN:  calEn_nxt = merge(calEn_r, avs_writedata[7:0],
                                               avs_byteenable[0], `IMC_MASK_CALEN);
            `IMC_IDX_CALCFG: calCfg_nxt = merge(calCfg_r, avs_writedata[7:0],
                                                avs_byteenable[0], `IMC_MASK_CALCFG);
            default: ;  // Unmapped writes are dropped
         endcase
      end
      // Request taken: answer next cycle, read data registered now
      if ((avs_read || avs_write) && !ack_r) begin
         ack_nxt = 1'b1;
         if (avs_read) begin
            case (idx)
               `IMC_IDX_ROUTE:  rdata_nxt = {24'h000000, routeReg_r};
               `IMC_IDX_CALEN:  rdata_nxt = {24'h000000, calEn_r};
               `IMC_IDX_CALCFG: rdata_nxt = {24'h000000, calCfg_r};
               // Status: done flag, background active, engine state
               `IMC_IDX_STATUS: rdata_nxt = {24'h000000, 2'b00, engState,
                                             1'b0, bgActive, engFgDone};
               default:         rdata_nxt = 32'h00000000; // Unmapped reads zero
            endcase
         end
      end
   end

   // Routing applied only when calibration starts
   always_comb begin
      route_nxt = route_r;
      if (applyPulse) begin
         if (singleChannelMode) begin
            // Swap bit has no effect here
            route_nxt.chanASamplesB  = 1'b0;
            route_nxt.singleUsesB    = (routeReg_r[1:0] == 2'h2);
            route_nxt.dualInterleave = (routeReg_r[1:0] == 2'h3);
            route_nxt.chanBSamplesA  = 1'b0;
            route_nxt.chanBSamplesB  = (routeReg_r[1:0] == 2'h3);
         end else begin
            // Single field has no effect here
            route_nxt.singleUsesB    = 1'b0;
            route_nxt.dualInterleave = 1'b0;
            route_nxt.chanASamplesB  = routeReg_r[`IMC_ROUTE_SWAP];
            route_nxt.chanBSamplesA  = routeReg_r[`IMC_ROUTE_SWAP];
            route_nxt.chanBSamplesB  = !routeReg_r[`IMC_ROUTE_SWAP];
         end
      end
   end

   // State registers
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         routeReg_r <= `IMC_RST_ROUTE;
         calEn_r    <= `IMC_RST_CALEN;
         calCfg_r   <= `IMC_RST_CALCFG;
         rdata_r    <= 32'h00000000;
         ack_r      <= 1'b0;
         route_r    <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
      end else begin
         routeReg_r <= routeReg_nxt;
         calEn_r    <= calEn_nxt;
         calCfg_r   <= calCfg_nxt;
         rdata_r    <= rdata_nxt;
         ack_r      <= ack_nxt;
         route_r    <= route_nxt;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign avs_readdata    = rdata_r;
   assign route           = route_r;
   assign calApplied      = calSel;
   assign fgComplete      = engFgDone;
   assign dividerReset    = !calEn_r[0];

   // Steps of a calibration start
   sequence startStep_s;
      applyPulse;
   endsequence
   sequence clearStep_s;
      engState == CAL_CLEAR;
   endsequence
   sequence heldStep_s;
      engState == CAL_HOLD;
   endsequence

   // Divider reset tracks enable, engine held one cycle on
   div_reset_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      $fell(calEn_r[0]) |-> dividerReset ##1 heldStep_s) else $error("dividers not reset");
   // Swap crosses inputs in dual mode
   swap_route_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      applyPulse && !singleChannelMode && routeReg_r[4] |=> route.chanASamplesB
      && route.chanBSamplesA) else $error("swap not applied");
   // Swap ignored in single mode
   swap_ignore_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      applyPulse && singleChannelMode |=> !route.chanASamplesB)
      else $error("swap used in single mode");
   // Input B chosen by code 2
   single_b_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      applyPulse && singleChannelMode && routeReg_r[1:0] == 2'h2 |=>
      route.singleUsesB && !route.dualInterleave) else $error("input B wrong");
   // Single field ignored in dual
   single_ignore_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      applyPulse && !singleChannelMode |=> !route.singleUsesB && !route.dualInterleave)
      else $error("single field used in dual");
   // Code 3 interleaves
   interleave_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      applyPulse && singleChannelMode && routeReg_r[1:0] == 2'h3 |=>
      route.dualInterleave && route.chanBSamplesB) else $error("no interleave");
   // Routing steady between starts
   route_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      !$past(applyPulse) |-> $stable(route)) else $error("route changed early");
   // Offset gating
   offset_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (calApplied.bgOffset |-> calApplied.bgRun) and
      (calApplied.fgOffset |-> calApplied.fgRun)) else $error("offset ungated");
   // Reserved bits stay zero; for the route register only bits 7:5
   reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      routeReg_r[7:5] == 3'h0 && calEn_r[7:1] == 7'h00 && calCfg_r[7:4] == 4'h0)
      else $error("reserved bit set");
   // Background only entered while bit 1 was set
   bg_follow_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      bgActive |-> $past(calCfg_r[1])) else $error("background without enable");
   // Start always enters the clear phase
   cal_start_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      startStep_s |=> clearStep_s) else $error("start skipped clear");
   // Foreground pass skipped when bit 0 is low
   fg_skip_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      clearStep_s ##0 !calSel.fgRun |=> engState != CAL_FORE)
      else $error("foreground not skipped");
   // Done flag only once the foreground pass is over
   done_state_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      fgComplete |-> engState inside {CAL_BACK, CAL_IDLE}) else $error("done flag early");
endmodule : imc_top

// ### test/test_input_mux_calibration_control.sv
// Self-checking bench for the input routing and calibration control block.
// Assumes imc_pkg is compiled first and imc_defines.svh is on the include path.
`timescale 1ns/1ns
`include "imc_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errTotal++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_input_mux_calibration_control
   import imc_pkg::*;
;
   logic        ref_clk;            // Bench clock, 8 ns
   logic        nrst;               // Synchronous reset, active low
   logic [9:0]  avs_address;        // Byte address
   logic        avs_read;           // Read request
   logic        avs_write;          // Write request
   logic [31:0] avs_writedata;      // Write data, low byte used
   logic [3:0]  avs_byteenable;     // Byte lanes
   logic [31:0] avs_readdata;       // Read data
   logic        avs_waitrequest;    // Slave stall
   logic        singleChannelMode;  // Converter mode setting
   logic        outputLinkEnable;   // Link enable level
   imc_route_s  route;              // Applied routing
   imc_calsel_s calApplied;         // Applied calibration select
   logic        dividerReset;       // Divider reset level
   logic        fgComplete;         // Foreground done flag
   logic        bgActive;           // Background running
   int          errTotal;           // Mismatch count
   int          comparisons;        // Comparison count
   int          seed;               // Random seed
   logic [31:0] rd;                 // Last read data
   // Device under test with shortened calibration counts
   imc_top #(.FG_CYCLES(16'h0004), .CLR_CYCLES(16'h0002)) uut (
      .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .singleChannelMode(singleChannelMode),
      .outputLinkEnable(outputLinkEnable), .route(route), .calApplied(calApplied),
      .dividerReset(dividerReset), .fgComplete(fgComplete), .bgActive(bgActive));
   // Clock generator
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Expected routing from register value and mode
   function automatic logic [4:0] expRoute(input logic [7:0] r, input logic s);
      if (!s)
         return {r[4], r[4], !r[4], 1'b0, 1'b0};
      return {1'b0, 1'b0, r[1:0] == 2'h3, r[1:0] == 2'h2, r[1:0] == 2'h3};
   endfunction : expRoute
   // Fields that the rules fix for this mode and code
   function automatic logic [4:0] routeMask(input logic [7:0] r, input logic s);
      if (!s)
         return 5'h1d;
      return (r[1:0] == 2'h3) ? 5'h1b : 5'h03;
   endfunction : routeMask
   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      int n;
      avs_address   <= a;
      avs_writedata <= {24'h0, d};
      avs_read      <= !wr;
      avs_write     <= wr;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
         `CHK(avs_waitrequest, 1'b0)
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask : bus
   // Bounded wait for the foreground done flag
   task automatic waitDone(output int n);
      n = 0;
      while (fgComplete !== 1'b1 && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      @(posedge ref_clk);
   endtask : waitDone
   // Verdict and end of run
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", comparisons, errTotal);
      if (errTotal == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude
   // Watchdog against a hung handshake
   initial begin
      #200000;
      errTotal++;
      conclude();
   end
   // Main sequence
   initial begin
      logic [9:0]  addrs [4];
      logic [7:0]  exps [4];
      logic [7:0]  rv;
      logic [3:0]  cfg;
      logic [4:0]  old;
      logic        md;
      int          n;
      addrs = '{10'h180, 10'h184, 10'h188, 10'h1f0};
      exps = '{8'h13, 8'h01, 8'h0f, 8'h00};
      seed = 32'h4bf8;
      errTotal = 0;
      comparisons = 0;
      nrst = 1'b0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      avs_byteenable = 4'h1;
      singleChannelMode = 1'b0;
      outputLinkEnable = 1'b0;
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      // Reset values and the calibration that follows reset
      bus(1'b0, 10'h180, 8'h00, rd); `CHK(rd, 32'h01)
      bus(1'b0, 10'h184, 8'h00, rd); `CHK(rd, 32'h01)
      bus(1'b0, 10'h188, 8'h00, rd); `CHK(rd, 32'h01)
      `CHK(calApplied, 4'h8)
      `CHK(dividerReset, 1'b0)
      waitDone(n); `CHK(fgComplete, 1'b1)
      `CHK(route, 5'h04)
      `CHK(bgActive, 1'b0)
      $display("Test reset values finished");
      // Reserved bits and an unmapped word
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, addrs[i], 8'hff, rd);
         bus(1'b0, addrs[i], 8'h00, rd); `CHK(rd, {24'h0, exps[i]})
      end
      bus(1'b1, 10'h180, 8'h01, rd);
      bus(1'b1, 10'h188, 8'h01, rd);
      $display("Test reserved bits finished");
      // Routing and calibration selections, corners first then random
      for (int i = 0; i < 16; i++) begin
         rd = $random(seed);
         md = (i < 6) ? i[0] : rd[8];
         rv = {3'h0, rd[4], 2'h0, (i < 6) ? 2'(1 + (i / 2) % 3) : 2'(1 + rd[15:9] % 3)};
         cfg = (i < 4) ? 4'(i) : rd[3:0];
         old = route;
         bus(1'b1, 10'h180, rv, rd); `CHK(route, old)
         outputLinkEnable <= 1'b0;
         @(posedge ref_clk);
         bus(1'b1, 10'h184, 8'h00, rd); `CHK(dividerReset, 1'b1)
         repeat (2) @(posedge ref_clk);
         `CHK(fgComplete, 1'b0)
         bus(1'b1, 10'h188, {4'h0, cfg}, rd);
         `CHK(calApplied, {cfg[0], cfg[1], cfg[2] & cfg[0], cfg[3] & cfg[1]})
         singleChannelMode <= md;
         bus(1'b1, 10'h184, 8'h01, rd); `CHK(dividerReset, 1'b0)
         waitDone(n); `CHK(cfg[0] ? (n >= 5 && n <= 8) : n <= 4, 1'b1)
         `CHK(route & routeMask(rv, md), expRoute(rv, md) & routeMask(rv, md))
         `CHK(bgActive, cfg[1])
         bus(1'b0, 10'h18c, 8'h00, rd); `CHK(rd[1:0], {cfg[1], 1'b1})
         outputLinkEnable <= 1'b1;
         @(posedge ref_clk);
      end
      $display("Test routing and calibration finished");
      conclude();
   end
endmodule : test_input_mux_calibration_control
